// [verilog/bscr_pkg.sv]
// Shared constants and types for the boot strap, clock and reset loader.
// Assumes a single 125 MHz clock domain and a 32-bit APB register port.
package bscr_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STAT_OFS     = 8'h04;
  localparam logic [7:0] STRAP_OFS    = 8'h08;
  localparam logic [7:0] CORE_CNT_OFS = 8'h0c;
  localparam logic [7:0] EXT_CNT_OFS  = 8'h10;

  // ==========================================================================
  // Control register fields
  localparam int          CTRL_BOOT_DONE_BIT = 0;
  localparam logic [31:0] CTRL_RST           = 32'h0000_0000;

  // ==========================================================================
  // Status register fields
  localparam int STAT_MODE_LSB      = 0;
  localparam int STAT_RATIO_LSB     = 8;
  localparam int STAT_RATIO_BAD_BIT = 11;
  localparam int STAT_MASTER_BIT    = 12;
  localparam int STAT_CLK_OE_BIT    = 13;
  localparam int STAT_KEEP_BIT      = 14;
  localparam int STAT_BSEL_OE_BIT   = 15;

  // ==========================================================================
  // Latched strap register fields
  localparam int STRAP_EPROM_BIT = 0;
  localparam int STRAP_LINK_BIT  = 1;
  localparam int STRAP_BSEL_BIT  = 2;
  localparam int STRAP_RATIO_LSB = 4;
  localparam int STRAP_ID_LSB    = 8;

  // ==========================================================================
  // Boot modes, one-hot
  typedef enum logic [4:0] {
    BOOT_EPROM = 5'b00001,
    BOOT_HOST  = 5'b00010,
    BOOT_LINK  = 5'b00100,
    BOOT_NONE  = 5'b01000,
    BOOT_RSVD  = 5'b10000
  } bscr_boot_e;

  // ==========================================================================
  // Clock ratio and reset defaults
  // Sixteen 3-bit entries, entry k at bits 3k+2..3k; zero marks an unused
  // code. Default: code 0 gives 2, code 1 gives 3, code 2 gives 4.
  localparam logic [47:0] RATIO_MAP_DFLT = 48'h0000_0000_011a;
  localparam logic [2:0]  RATIO_SAFE     = 3'h2;
  localparam logic [31:0] RESET_VEC_DFLT = 32'h0000_0100;
  localparam logic [1:0]  KEEP_ID_HIGH   = 2'h0;

endpackage

// [verilog/bscr_strap_decode.sv]
// Combinational decode of the boot straps and the core ratio straps.
// Assumes its inputs are already latched and stable.
`timescale 1ns/100ps
module bscr_strap_decode #(
  parameter logic [47:0] RATIO_MAP = bscr_pkg::RATIO_MAP_DFLT
) (
  input  wire logic              eprom_boot_strap,
  input  wire logic              link_boot_strap,
  input  wire logic              boot_select_level,
  input  wire logic [3:0]        core_ratio_straps,
  output bscr_pkg::bscr_boot_e   boot_mode,
  output logic      [2:0]        core_ratio,
  output logic                   ratio_bad
);

  // ==========================================================================
  // Boot mode
  wire [2:0] code = {eprom_boot_strap, link_boot_strap, boot_select_level};

  always_comb begin
    unique case (code)
      3'b100, 3'b101: boot_mode = bscr_pkg::BOOT_EPROM;
      3'b001:         boot_mode = bscr_pkg::BOOT_HOST;
      3'b011:         boot_mode = bscr_pkg::BOOT_LINK;
      3'b000:         boot_mode = bscr_pkg::BOOT_NONE;
      default:        boot_mode = bscr_pkg::BOOT_RSVD;
    endcase
  end

  // ==========================================================================
  // Ratio lookup; an unused code falls back to the slowest legal ratio.
  wire [2:0] map_entry = RATIO_MAP[{core_ratio_straps, 2'b00} -
                                   {2'b00, core_ratio_straps} +: 3];
  assign ratio_bad  = (map_entry < 3'h2) || (map_entry > 3'h4);
  assign core_ratio = ratio_bad ? bscr_pkg::RATIO_SAFE : map_entry;

endmodule

// [verilog/bscr_top.sv]
// Boot strap, core clock ratio and reset entry logic with an APB port.
// Assumes straps are synchronous to clock and the clock never stops.
`timescale 1ns/100ps
module bscr_top #(
  parameter logic [47:0] RATIO_MAP = bscr_pkg::RATIO_MAP_DFLT,
  parameter logic [31:0] RESET_VEC = bscr_pkg::RESET_VEC_DFLT
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        eprom_boot_strap,
  input  wire logic        link_boot_strap,
  input  wire logic        boot_memory_select_in,
  output logic             boot_memory_select_out,
  output logic             boot_memory_select_oe,
  input  wire logic [3:0]  core_ratio_straps,
  input  wire logic [2:0]  processor_id_straps,
  input  wire logic        bus_master,
  input  wire logic        host_bus_grant_n,
  output logic             local_clock_out,
  output logic             local_clock_oe,
  output logic             local_clock_keep_en,
  output logic [2:0]       core_ratio,
  output logic             ext_port_cycle,
  output logic             fetch_start,
  output logic [31:0]      fetch_addr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ==========================================================================
  // Strap capture
  // Straps follow the pins while reset is high and freeze at release, so a
  // board that moves a strap later has no effect until the next reset.
  logic       eprom_q;
  logic       link_q;
  logic       bsel_q;
  logic [3:0] ratio_q;
  logic [2:0] id_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      eprom_q <= eprom_boot_strap;
      link_q  <= link_boot_strap;
      bsel_q  <= boot_memory_select_in;
      ratio_q <= core_ratio_straps;
      id_q    <= processor_id_straps;
    end
  end

  // ==========================================================================
  // Decode
  bscr_pkg::bscr_boot_e boot_mode;
  logic [2:0]           ratio_dec;
  logic                 ratio_bad;

  bscr_strap_decode #(
    .RATIO_MAP (RATIO_MAP)
  ) u_decode (
    .eprom_boot_strap  (eprom_q),
    .link_boot_strap   (link_q),
    .boot_select_level (bsel_q),
    .core_ratio_straps (ratio_q),
    .boot_mode         (boot_mode),
    .core_ratio        (ratio_dec),
    .ratio_bad         (ratio_bad)
  );

  // ==========================================================================
  // Register decode
  logic [31:0] ctrl;
  logic [31:0] core_cycles;
  logic [31:0] ext_cycles;

  wire setup_phase = psel & ~penable;
  wire wr_commit   = psel & penable & pready & pwrite;
  wire hit_ctrl    = (paddr == bscr_pkg::CTRL_OFS);
  wire hit_stat    = (paddr == bscr_pkg::STAT_OFS);
  wire hit_strap   = (paddr == bscr_pkg::STRAP_OFS);
  wire hit_core    = (paddr == bscr_pkg::CORE_CNT_OFS);
  wire hit_ext     = (paddr == bscr_pkg::EXT_CNT_OFS);
  wire hit_any     = hit_ctrl | hit_stat | hit_strap | hit_core | hit_ext;
  wire boot_done   = ctrl[bscr_pkg::CTRL_BOOT_DONE_BIT];
  wire is_eprom    = (boot_mode == bscr_pkg::BOOT_EPROM);

  // Only the control register is writable; other writes are ignored.
  wire [31:0] strb_mask;

  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign strb_mask[8*b +: 8] = {8{pstrb[b]}};
  end

  wire [31:0] next_ctrl = (ctrl & ~strb_mask) | (pwdata & strb_mask &
                          32'h0000_0001);

  wire [31:0] stat_word =
    ({27'h0, boot_mode}     << bscr_pkg::STAT_MODE_LSB) |
    ({29'h0, core_ratio}    << bscr_pkg::STAT_RATIO_LSB) |
    ({31'h0, ratio_bad}     << bscr_pkg::STAT_RATIO_BAD_BIT) |
    ({31'h0, bus_master}    << bscr_pkg::STAT_MASTER_BIT) |
    ({31'h0, local_clock_oe} << bscr_pkg::STAT_CLK_OE_BIT) |
    ({31'h0, local_clock_keep_en} << bscr_pkg::STAT_KEEP_BIT) |
    ({31'h0, boot_memory_select_oe} << bscr_pkg::STAT_BSEL_OE_BIT);

  wire [31:0] strap_word =
    ({31'h0, eprom_q} << bscr_pkg::STRAP_EPROM_BIT) |
    ({31'h0, link_q}  << bscr_pkg::STRAP_LINK_BIT) |
    ({31'h0, bsel_q}  << bscr_pkg::STRAP_BSEL_BIT) |
    ({28'h0, ratio_q} << bscr_pkg::STRAP_RATIO_LSB) |
    ({29'h0, id_q}    << bscr_pkg::STRAP_ID_LSB);

  wire [31:0] read_word = hit_ctrl  ? ctrl :
                          hit_stat  ? stat_word :
                          hit_strap ? strap_word :
                          hit_core  ? core_cycles :
                          hit_ext   ? ext_cycles : 32'h0000_0000;

  // ==========================================================================
  // APB slave
  // Answer is staged in the setup cycle so every bus output is a flop and
  // each transfer still completes in its first access cycle.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~hit_any;
      prdata  <= (setup_phase & ~pwrite) ? read_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl <= bscr_pkg::CTRL_RST;
    end else if (wr_commit && hit_ctrl) begin
      ctrl <= next_ctrl;
    end
  end

  // ==========================================================================
  // Core clock ratio and cycle counters
  // The ratio register reloads the decoded straps every cycle out of reset; the
  // strap latch keeps it constant during operation even if the pins later move.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      core_ratio     <= bscr_pkg::RATIO_SAFE;
      core_cycles    <= 32'h0000_0000;
      ext_cycles     <= 32'h0000_0000;
      ext_port_cycle <= 1'b0;
    end else begin
      core_ratio     <= ratio_dec;
      core_cycles    <= core_cycles + {29'h0, core_ratio};
      ext_cycles     <= ext_cycles + 32'h0000_0001;
      ext_port_cycle <= 1'b1;
    end
  end

  // ==========================================================================
  // Boot memory select pin
  // In EPROM mode the pin is an active-low chip select held low until
  // software marks the boot load as done; elsewhere it is never driven.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      boot_memory_select_oe  <= 1'b0;
      boot_memory_select_out <= 1'b1;
    end else begin
      boot_memory_select_oe  <= is_eprom;
      boot_memory_select_out <= ~is_eprom | boot_done;
    end
  end

  // ==========================================================================
  // Local clock output
  // The pin forwards the input clock itself; a divided flop copy would run
  // at half rate. Only its enable and keeper control are registered.
  assign local_clock_out = clock;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      local_clock_oe      <= 1'b0;
      local_clock_keep_en <= 1'b0;
    end else begin
      local_clock_oe      <= bus_master & host_bus_grant_n;
      local_clock_keep_en <= (id_q[2:1] == bscr_pkg::KEEP_ID_HIGH);
    end
  end

  // ==========================================================================
  // Reset entry
  logic in_reset_d;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      in_reset_d  <= 1'b1;
      fetch_start <= 1'b0;
      fetch_addr  <= 32'h0000_0000;
    end else begin
      in_reset_d  <= 1'b0;
      fetch_start <= in_reset_d;
      fetch_addr  <= RESET_VEC;
    end
  end

endmodule

// [dv/bscr_board.sv]
// Board model: strap resistors, the boot select pin and the boot memory.
// Assumes the bench changes the strap word around each reset and once after boot done.
`timescale 1ns/100ps
module bscr_board (
  input  wire logic [11:0] cfg,
  input  wire logic        sel_out,
  input  wire logic        sel_oe,
  output logic             eprom_boot_strap,
  output logic             link_boot_strap,
  output logic             sel_in,
  output logic [3:0]       core_ratio_straps,
  output logic [2:0]       processor_id_straps,
  output logic             eprom_sel
);
  // ==========================================================================
  // Straps
  // Straps are plain resistors, so they follow the word with no delay.
  assign eprom_boot_strap    = cfg[0];
  assign link_boot_strap     = cfg[1];
  assign core_ratio_straps   = cfg[7:4];
  assign processor_id_straps = cfg[10:8];
  // The pin shows the device's drive when enabled, else the resistor.
  assign sel_in    = sel_oe ? sel_out : cfg[2];
  assign eprom_sel = sel_oe & ~sel_out;
endmodule

// [dv/bscr_props.sv]
// Port checker for the strap loader, bound into every bscr_top.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module bscr_props #(
  parameter logic [47:0] RATIO_MAP = bscr_pkg::RATIO_MAP_DFLT,
  parameter logic [31:0] RESET_VEC = bscr_pkg::RESET_VEC_DFLT
) (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        eprom_boot_strap,
  input wire logic        link_boot_strap,
  input wire logic        boot_memory_select_oe,
  input wire logic [3:0]  core_ratio_straps,
  input wire logic [2:0]  processor_id_straps,
  input wire logic        bus_master,
  input wire logic        host_bus_grant_n,
  input wire logic        local_clock_oe,
  input wire logic        local_clock_keep_en,
  input wire logic [2:0]  core_ratio,
  input wire logic        ext_port_cycle,
  input wire logic        fetch_start,
  input wire logic [31:0] fetch_addr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic [8:0] lat;
  logic       run;
  logic       run2;
  wire  [2:0] map_n = RATIO_MAP[3*lat[5:2] +: 3];
  // Only 2, 3 and 4 are legal multipliers; anything else runs safe.
  wire  [2:0] exp_n = (map_n inside {3'h2, 3'h3, 3'h4}) ? map_n :
                      bscr_pkg::RATIO_SAFE;
  wire        mapped = paddr <= 8'h10 && paddr[1:0] == 2'h0;
  // Mirror of the strap latch, so checks survive straps moving later.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lat <= {processor_id_straps, core_ratio_straps,
              link_boot_strap, eprom_boot_strap};
    end
    run  <= !sys_rst;
    run2 <= run;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence fetch_seq;
    !fetch_start ##1 fetch_start && fetch_addr == RESET_VEC ##1 !fetch_start;
  endsequence
  chk_fetch_pulse: assert property ($fell(sys_rst) |-> fetch_seq)
    else $error("fetch start pulse wrong");
  chk_bsel_dir: assert property (run |-> boot_memory_select_oe ==
    (lat[0] && !lat[1])) else $error("boot select direction wrong");
  chk_ratio_value: assert property (run |-> core_ratio == exp_n)
    else $error("core ratio wrong");
  chk_ratio_frozen: assert property (run2 |-> $stable(core_ratio))
    else $error("core ratio changed");
  chk_clk_drive: assert property (run |-> local_clock_oe ==
    $past(bus_master && host_bus_grant_n)) else $error("clock oe wrong");
  chk_keeper_id: assert property (run |-> local_clock_keep_en ==
    (lat[8:7] == 2'h0)) else $error("keeper enable wrong");
  chk_port_rate: assert property (run |-> ext_port_cycle)
    else $error("port cycle idle");
  chk_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  chk_apb_unmapped: assert property (psel && !penable && !mapped |=> pslverr)
    else $error("unmapped access not refused");
endmodule
bind bscr_top bscr_props #(.RATIO_MAP(RATIO_MAP), .RESET_VEC(RESET_VEC))
  u_bscr_props (.*);

// [dv/bscr_bench.sv]
// Self-checking bench for the strap loader with the board model.
// Assumes APB answers in the first access cycle.
`timescale 1ns/100ps
module bscr_bench;
  typedef struct packed {
    logic [11:0] cfg;
    logic [4:0]  mode;
    logic        oe;
    logic [2:0]  n;
    logic        keep;
  } bscr_row_s;
  bscr_row_s rows [7] = '{'{12'h001, 5'h01, 1'h1, 3'h2, 1'h1},
    '{12'h114, 5'h02, 1'h0, 3'h3, 1'h1}, '{12'h226, 5'h04, 1'h0, 3'h4, 1'h0},
    '{12'h330, 5'h08, 1'h0, 3'h2, 1'h0}, '{12'h402, 5'h10, 1'h0, 3'h2, 1'h0},
    '{12'h617, 5'h10, 1'h0, 3'h3, 1'h0}, '{12'h725, 5'h01, 1'h1, 3'h4, 1'h0}};
  logic        clock = 1'h0, sys_rst = 1'h1, bus_master = 1'h1;
  logic        host_bus_grant_n = 1'h1, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, perr, eprom_boot_strap, link_boot_strap;
  logic        boot_memory_select_in, boot_memory_select_out, eprom_sel;
  logic        boot_memory_select_oe, local_clock_oe, local_clock_keep_en;
  logic        ext_port_cycle, fetch_start, pready, pslverr, local_clock_out;
  logic [11:0] cfg = 12'h001;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, fetch_addr, q, c1, c2, e1, e2;
  logic [3:0]  core_ratio_straps;
  logic [3:0]  pstrb = 4'hf;
  logic [2:0]  processor_id_straps, core_ratio;
  int          n_fail = 0, n_checks = 0;
  initial forever #4 clock = ~clock;
  bscr_board u_bscr_board (.cfg(cfg), .sel_out(boot_memory_select_out),
    .sel_oe(boot_memory_select_oe), .eprom_boot_strap(eprom_boot_strap),
    .link_boot_strap(link_boot_strap), .sel_in(boot_memory_select_in),
    .core_ratio_straps(core_ratio_straps), .eprom_sel(eprom_sel),
    .processor_id_straps(processor_id_straps));
  bscr_top u_bscr_top (.*);
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask
  task automatic hang;
    n_fail++;
    stop_test();
  endtask
  // Entered just after a rising edge; leaves one idle cycle behind it.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    for (k = 0; k < 16 && pready !== 1'h1; k++) @(posedge clock);
    if (k == 16) hang();
    q = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask
  initial begin
    int k;
    @(posedge clock);
    foreach (rows[i]) begin
      cfg <= rows[i].cfg;
      sys_rst <= 1'h1;
      repeat (4) @(posedge clock);
      chk("reset ratio", core_ratio, 3'h2);
      chk("reset vector", fetch_addr, 32'h0);
      sys_rst <= 1'h0;
      for (k = 0; k < 4 && fetch_start !== 1'h1; k++) @(posedge clock);
      if (k == 4) hang();
      chk("vector", fetch_addr, bscr_pkg::RESET_VEC_DFLT);
      @(posedge clock);
      chk("select oe", boot_memory_select_oe, rows[i].oe);
      chk("ratio", core_ratio, rows[i].n);
      chk("keeper", local_clock_keep_en, rows[i].keep);
      apb(1'h0, bscr_pkg::STAT_OFS, 32'h0);
      chk("mode", q[4:0], rows[i].mode);
      chk("mapped err", perr, 1'h0);
      apb(1'h0, bscr_pkg::STRAP_OFS, 32'h0);
      chk("straps", q, 32'(rows[i].cfg));
    end
    // The last row leaves EPROM boot with the chip select low.
    chk("eprom select", eprom_sel, 1'h1);
    apb(1'h1, bscr_pkg::CTRL_OFS, 32'h1);
    // The pin register follows the control bit one edge after the write.
    @(posedge clock);
    chk("select released", eprom_sel, 1'h0);
    apb(1'h0, bscr_pkg::CTRL_OFS, 32'h0);
    chk("boot done", q, 32'h1);
    cfg <= 12'h000;
    repeat (3) @(posedge clock);
    chk("ratio frozen", core_ratio, 3'h4);
    chk("select oe frozen", boot_memory_select_oe, 1'h1);
    apb(1'h0, bscr_pkg::CORE_CNT_OFS, 32'h0);
    c1 = q;
    apb(1'h0, bscr_pkg::CORE_CNT_OFS, 32'h0);
    c2 = q;
    apb(1'h0, bscr_pkg::EXT_CNT_OFS, 32'h0);
    e1 = q;
    apb(1'h0, bscr_pkg::EXT_CNT_OFS, 32'h0);
    e2 = q;
    chk("core count", c2 - c1, 32'hc);
    chk("port count", e2 - e1, 32'h3);
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped err", perr, 1'h1);
    chk("unmapped data", q, 32'h0);
    for (int j = 0; j < 4; j++) begin
      {bus_master, host_bus_grant_n} <= 2'(j);
      repeat (2) @(posedge clock);
      chk("clock oe", local_clock_oe, j == 3);
    end
    // Looked at mid-phase so the forwarded clock has settled.
    #2 chk("clock out high", local_clock_out, 1'h1);
    #4 chk("clock out low", local_clock_out, 1'h0);
    stop_test();
  end
endmodule
